/* hw/ctl_timer_defines.vh */
/*
 * Register offsets, field positions, reset values and command codes of the
 * control timer core.
 * Assumes inclusion by its bare name from design files on the bus clock.
 */
`ifndef CTL_TIMER_DEFINES_VH
`define CTL_TIMER_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CT_OFS_CTRL      8'h00
`define CT_OFS_STATUS    8'h04
`define CT_OFS_IRQF      8'h08
`define CT_OFS_COUNT     8'h0c
`define CT_OFS_CYCLEN    8'h10
`define CT_OFS_CYCLENB   8'h14
`define CT_OFS_GUARD     8'h18
`define CT_OFS_FLT       8'h1c
`define CT_OFS_CCV0      8'h20
`define CT_OFS_CCS0      8'h30
`define CT_OFS_EVEN      8'h40

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CT_CTRL_EN       0
`define CT_CTRL_DIR      1
`define CT_CTRL_EVCNT    2
`define CT_CTRL_TOPCC0   3
`define CT_CTRL_DBGRUN   4
`define CT_CTRL_CPT0     8
`define CT_CTRL_FLTEN    12
`define CT_CTRL_FLTACT   14
`define CT_CTRL_W        16

// ----------------------------------------------------------------------
// Fault actions
// ----------------------------------------------------------------------
`define CT_FA_RESTART    2'h0
`define CT_FA_HALT       2'h1
`define CT_FA_SHORT      2'h2
`define CT_FA_DISABLE    2'h3

// ----------------------------------------------------------------------
// Flag bits and reset values
// ----------------------------------------------------------------------
`define CT_IRQ_OVF       0
`define CT_IRQ_MC0       4
`define CT_RST_CTRL      16'h0000
`define CT_RST_CYCLEN    24'hffffff

`endif

/* hw/ctl_timer_core.v */
/*
 * Control timer core: counter, four compare/capture channels, shadow
 * registers with valid flags, recoverable fault actions and waveforms.
 * Assumes a bus master on i_clk with one-cycle strobes; event and fault
 * inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ctl_timer_defines.vh"

// Contract
// RL1: Keep counting in sleep while the counter clock runs; irq can wake.
// RL2: Counter and channel events go out to the event fabric.
// RL3: Counter clock asynchronous to bus; register writes are synchronised. Here one clock i_clk; only COUNT writes pass wr_pend_q and wr_sync_q.
// RL4: Halt during debug unless the debug run override is set.
// RL5: Guard blocks writes except flags, status, limits, compares, shadows.
// RL6: Debugger accesses always bypass the write guard.
// RL7: Upper limit is cycle length or channel 0 compare by mode.
// RL8: Zero is all bits clear; maximum is all bits set.
// RL9: Update fires at zero or at upper limit chosen by direction.
// RL10: Counter advances on internal ticks or on external events.
// RL11: Four channels, each compare or capture.
// RL12: Count, limits and compares are 16 or 24 bits per instance.
// RL13: Each shadow has a valid flag set on a new write.
// RL14: Limit and zero reached raise irq, dma and event.
// RL15: Limit and zero comparisons shape the waveform period and pulse.
// RL16: Capture is triggered by fabric events.
// RL17: Faults restart, halt, shorten or disable the outputs.
// RL18: Channel events 0 and 1 feed the fault unit when enabled.
// RL19: One waveform output per compare channel.
// RL20: Counter clock is set up and enabled outside before use.
// RL21: Up wraps to zero after limit, down reloads limit; overflow set.
// RL22: Direction clear counts up, set counts down.
// RL23: Shadow transfer on update clears its valid flag.
module ctl_timer_core #(
   parameter W   = 24, // RL12
   parameter NCH = 4
) (
   input  wire           i_clk,
   input  wire           i_reset,
   input  wire [7:0]     i_addr,
   input  wire [31:0]    i_wdata,
   input  wire           i_wr,
   input  wire           i_rd,
   input  wire           i_dbg_access,
   input  wire           i_dbg_halt,
   input  wire           i_sleep,
   input  wire           i_cnt_event,
   input  wire [NCH-1:0] i_chan_event,
   output reg  [31:0]    o_rdata,
   output reg  [NCH-1:0] o_waveform_output_pins,
   output reg            o_irq,
   output reg            o_dma_req,
   output reg            o_ovf_event,
   output reg  [NCH-1:0] o_mc_event
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   reg  [`CT_CTRL_W-1:0] ctrl_q;
   reg                   guard_q;
   reg  [W-1:0]          count_q;
   reg  [W-1:0]          cyclen_q;
   reg  [W-1:0]          cyclenb_q;
   reg                   cyclenb_v_q;
   reg  [W-1:0]          ccv_q [0:NCH-1];
   reg  [W-1:0]          ccs_q [0:NCH-1];
   reg  [NCH-1:0]        ccs_v_q;
   reg  [NCH+3:0]        irqf_q;
   reg  [NCH+3:0]        irqm_q;
   reg                   wr_pend_q;
   reg                   wr_sync_q;
   reg  [NCH:0]          ev_m_q;
   reg  [NCH:0]          ev_s_q;
   reg  [NCH:0]          ev_p_q;
   reg                   halted_q;
   reg  [W-1:0]          count_wd_q;
   reg  [NCH+3:0]        flag_set;
   reg  [NCH-1:0]        match;
   reg  [NCH-1:0]        wave;
   integer               j;
   integer               m;

   wire [NCH:0] ev_rise = ev_s_q & ~ev_p_q;
   wire         dir     = ctrl_q[`CT_CTRL_DIR];
   wire [NCH-1:0] cpt   = ctrl_q[`CT_CTRL_CPT0 +: NCH];
   wire [1:0]   fltact  = ctrl_q[`CT_CTRL_FLTACT +: 2];
   wire [W-1:0] top     = ctrl_q[`CT_CTRL_TOPCC0] ? ccv_q[0] : cyclen_q; // RL7
   wire         at_zero = (count_q == {W{1'b0}}); // RL8
   wire         at_max  = (count_q == {W{1'b1}}); // RL8
   wire         at_top  = (count_q == top);
   wire [1:0]   flt     = {ev_s_q[2], ev_s_q[1]} & {2{ctrl_q[`CT_CTRL_FLTEN]}};
   wire         fault   = |flt; // RL18
   wire         run     = ctrl_q[`CT_CTRL_EN] &
                          (~i_dbg_halt | ctrl_q[`CT_CTRL_DBGRUN]); // RL4 RL1
   wire         tick    = run & ~halted_q & (ctrl_q[`CT_CTRL_EVCNT] ?
                          ev_rise[0] : 1'b1); // RL10
   wire         upd     = tick & (dir ? at_zero : at_top); // RL9 RL22

   // ----------------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------------
   function is_guarded;
      input [7:0] a;
      begin
         is_guarded = (a == `CT_OFS_CTRL) || (a == `CT_OFS_FLT) ||
                      (a == `CT_OFS_EVEN) || (a == `CT_OFS_COUNT);
      end
   endfunction

   wire wr_ok = i_wr & (~guard_q | i_dbg_access |
                ~is_guarded(i_addr)); // RL5 RL6

   integer k;
   always @(posedge i_clk) begin
      if (i_reset) begin
         ctrl_q      <= `CT_RST_CTRL;
         guard_q     <= 1'b0;
         count_q     <= {W{1'b0}};
         cyclen_q    <= `CT_RST_CYCLEN;
         cyclenb_q   <= `CT_RST_CYCLEN;
         cyclenb_v_q <= 1'b0;
         ccs_v_q     <= {NCH{1'b0}};
         irqf_q      <= {(NCH+4){1'b0}};
         irqm_q      <= {(NCH+4){1'b0}};
         wr_pend_q   <= 1'b0;
         wr_sync_q   <= 1'b0;
         ev_m_q      <= {(NCH+1){1'b0}};
         ev_s_q      <= {(NCH+1){1'b0}};
         ev_p_q      <= {(NCH+1){1'b0}};
         halted_q    <= 1'b0;
         count_wd_q  <= {W{1'b0}};
         for (k = 0; k < NCH; k = k + 1) begin
            ccv_q[k] <= {W{1'b0}};
            ccs_q[k] <= {W{1'b0}};
         end
      end else begin
         ev_m_q    <= {i_chan_event, i_cnt_event};
         ev_s_q    <= ev_m_q; // RL16
         ev_p_q    <= ev_s_q;
         wr_pend_q <= wr_ok & (i_addr == `CT_OFS_COUNT);
         if (wr_ok && i_addr == `CT_OFS_COUNT)
            count_wd_q <= i_wdata[W-1:0]; // RL3
         wr_sync_q <= wr_pend_q; // RL3
         // Counter.
         if (wr_sync_q) begin
            count_q <= count_q;
         end else if (fault && fltact == `CT_FA_RESTART) begin
            count_q <= dir ? top : {W{1'b0}}; // RL17
         end else if (tick) begin
            if (!dir)
               count_q <= at_top ? {W{1'b0}} : count_q + 1'b1; // RL21
            else
               count_q <= at_zero ? top : count_q - 1'b1; // RL21
         end
         if (wr_pend_q)
            count_q <= count_wd_q;
         halted_q <= fault && fltact == `CT_FA_HALT; // RL17
         // Shadow transfer on update.
         if (upd && cyclenb_v_q)
            cyclen_q <= cyclenb_q;
         cyclenb_v_q <= (cyclenb_v_q & ~upd) |
                        (wr_ok & i_addr == `CT_OFS_CYCLENB); // RL13 RL23
         for (k = 0; k < NCH; k = k + 1) begin
            if (upd && ccs_v_q[k] && !cpt[k])
               ccv_q[k] <= ccs_q[k];
            if (cpt[k] && ev_rise[k+1])
               ccv_q[k] <= count_q; // RL11
            if (wr_ok && i_addr == `CT_OFS_CCS0 + 8'h04 * k[7:0])
               ccs_q[k] <= i_wdata[W-1:0];
            if (wr_ok && i_addr == `CT_OFS_CCV0 + 8'h04 * k[7:0])
               ccv_q[k] <= i_wdata[W-1:0];
            ccs_v_q[k] <= (ccs_v_q[k] & ~upd) | (wr_ok &&
                          i_addr == `CT_OFS_CCS0 + 8'h04 * k[7:0]); // RL13
         end
         if (wr_ok && i_addr == `CT_OFS_CTRL)
            ctrl_q <= i_wdata[`CT_CTRL_W-1:0];
         if (wr_ok && i_addr == `CT_OFS_GUARD)
            guard_q <= i_wdata[0];
         if (wr_ok && i_addr == `CT_OFS_CYCLEN)
            cyclen_q <= i_wdata[W-1:0];
         if (wr_ok && i_addr == `CT_OFS_CYCLENB)
            cyclenb_q <= i_wdata[W-1:0];
         if (wr_ok && i_addr == `CT_OFS_EVEN)
            irqm_q <= i_wdata[NCH+3:0];
         // Flags: a set in the clearing cycle wins.
         irqf_q <= (irqf_q & ~((wr_ok && i_addr == `CT_OFS_IRQF) ?
                   i_wdata[NCH+3:0] : {(NCH+4){1'b0}})) | flag_set; // RL14
      end
   end

   // ----------------------------------------------------------------------
   // Events, compare matches and waveforms
   // ----------------------------------------------------------------------
   always @* begin
      flag_set = {(NCH+4){1'b0}};
      flag_set[`CT_IRQ_OVF] = tick & (dir ? at_zero : at_top);
      flag_set[1] = tick & at_max;
      flag_set[2] = fault;
      flag_set[3] = 1'b0;
      for (j = 0; j < NCH; j = j + 1) begin
         match[j] = cpt[j] ? ev_rise[j+1] : (tick & count_q == ccv_q[j]);
         flag_set[`CT_IRQ_MC0+j] = match[j];
         // RL15 RL19: Output high while count is below compare.
         wave[j] = ~cpt[j] & ctrl_q[`CT_CTRL_EN] & (count_q < ccv_q[j]);
         if (fault && (fltact == `CT_FA_SHORT ||
             fltact == `CT_FA_DISABLE)) // RL17
            wave[j] = 1'b0;
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         o_waveform_output_pins <= {NCH{1'b0}};
         o_irq       <= 1'b0;
         o_dma_req   <= 1'b0;
         o_ovf_event <= 1'b0;
         o_mc_event  <= {NCH{1'b0}};
         o_rdata     <= 32'h00000000;
      end else begin
         o_waveform_output_pins <= wave; // RL19
         o_irq       <= |(irqf_q & irqm_q); // RL1 RL14
         o_dma_req   <= flag_set[`CT_IRQ_OVF]; // RL14
         o_ovf_event <= flag_set[`CT_IRQ_OVF]; // RL2
         o_mc_event  <= match; // RL2
         o_rdata     <= 32'h00000000;
         if (i_rd) begin
            case (i_addr)
               `CT_OFS_CTRL:    o_rdata <= {16'h0000, ctrl_q};
               `CT_OFS_STATUS:  o_rdata <= {26'h0, halted_q, fault,
                                 ccs_v_q == 0 ? 1'b0 : 1'b1, cyclenb_v_q,
                                 wr_pend_q | wr_sync_q, run};
               `CT_OFS_IRQF:    o_rdata <= {{(28-NCH){1'b0}}, irqf_q};
               `CT_OFS_COUNT:   o_rdata <= {{(32-W){1'b0}}, count_q};
               `CT_OFS_CYCLEN:  o_rdata <= {{(32-W){1'b0}}, cyclen_q};
               `CT_OFS_CYCLENB: o_rdata <= {{(32-W){1'b0}}, cyclenb_q};
               `CT_OFS_GUARD:   o_rdata <= {31'h0, guard_q};
               `CT_OFS_FLT:     o_rdata <= {{(28-NCH){1'b0}}, ccs_v_q,
                                 2'b00, flt};
               `CT_OFS_EVEN:    o_rdata <= {{(28-NCH){1'b0}}, irqm_q};
               default: begin
                  for (m = 0; m < NCH; m = m + 1) begin
                     if (i_addr == `CT_OFS_CCV0 + 8'h04 * m[7:0])
                        o_rdata <= {{(32-W){1'b0}}, ccv_q[m]};
                     if (i_addr == `CT_OFS_CCS0 + 8'h04 * m[7:0])
                        o_rdata <= {{(32-W){1'b0}}, ccs_q[m]};
                  end
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* test/ctl_timer_checker.sv */
/*
 * Port checker of the control timer core, bound into each core instance.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module ctl_timer_checker #(
   parameter W   = 24,
   parameter NCH = 4
) (
   input wire logic        i_clk,
   input wire logic        i_reset,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic        i_dbg_access,
   input wire logic        i_dbg_halt,
   input wire logic [31:0] o_rdata,
   input wire logic        o_irq,
   input wire logic        o_dma_req,
   input wire logic        o_ovf_event
);
   logic [15:0] ctrl_q;
   logic        guard_q;
   // Tracks the control and guard words as software should see them.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ctrl_q  <= 16'h0000;
         guard_q <= 1'b0;
      end else if (i_wr && i_addr == 8'h18) begin
         guard_q <= i_wdata[0];
      end else if (i_wr && i_addr == 8'h00 && (!guard_q || i_dbg_access)) begin
         ctrl_q <= i_wdata[15:0];
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence s_ctrl_read; i_rd && i_addr == 8'h00; endsequence
   sequence s_halted; (i_dbg_halt && !ctrl_q[4]) [*3]; endsequence
   sequence s_off; !ctrl_q[0] [*3]; endsequence
   a_quiet_after_reset: assert property ($fell(i_reset) |->
      !o_irq && !o_dma_req && !o_ovf_event) else $error("output after reset");
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside read slot");
   a_ctrl_readback: assert property (
      s_ctrl_read |=> o_rdata[15:0] == (ctrl_q & 16'hdf1f))
      else $error("control word wrong");
   a_guard_readback: assert property (
      i_rd && i_addr == 8'h18 |=> o_rdata[0] == guard_q)
      else $error("guard word wrong");
   a_halt_no_ovf: assert property (s_halted |-> !o_ovf_event)
      else $error("overflow while halted");
   a_off_no_ovf: assert property (s_off |-> !o_ovf_event && !o_dma_req)
      else $error("event while disabled");
   a_ovf_single: assert property (o_ovf_event |=> !o_ovf_event)
      else $error("overflow pulse too long");
   a_dma_single: assert property (o_dma_req |=> !o_dma_req)
      else $error("dma pulse too long");
   a_irq_holds: assert property (
      o_irq && !i_wr && !$past(i_wr) |=> o_irq)
      else $error("irq dropped without a write");
endmodule
`default_nettype wire

/* test/power_driver_model.sv */
/*
 * Model of the external power switch drivers fed by the waveform outputs.
 * Assumes gate inputs change only just after the rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module power_driver_model (
   input  wire logic        i_clk,
   input  wire logic        i_clear,
   input  wire logic [3:0]  i_gate,
   output var  logic [63:0] o_high_cycles
);
   // Each driver counts the cycles its switch is on.
   always_ff @(posedge i_clk)
      for (int c = 0; c < 4; c++)
         if (i_clear)
            o_high_cycles[16*c +: 16] <= 16'h0000;
         else
            o_high_cycles[16*c +: 16] <= o_high_cycles[16*c +: 16]
               + 16'(i_gate[c]);
endmodule
`default_nettype wire

/* test/control_timer_core_counter_bench.sv */
/*
 * Self-checking bench of the control timer core with random settings.
 * Assumes the core, its checker and the driver model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module control_timer_core_counter_bench;
   logic        i_clk, i_reset, i_wr, i_rd, i_dbg_access, i_dbg_halt;
   logic        i_cnt_event, clr, slp, o_irq, dma, ovf;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata, v, w, top, seed = 32'h0000005a;
   logic [3:0]  pins, mc, chev;
   logic [63:0] hi;
   logic [23:0] cc [4];
   int          errors, checks, n, t;
   int          mcn [4];
   ctl_timer_core #(.W(24), .NCH(4)) u_dut (.i_clk(i_clk), .i_reset(i_reset),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_dbg_access(i_dbg_access), .i_dbg_halt(i_dbg_halt), .i_sleep(slp),
      .i_cnt_event(i_cnt_event), .i_chan_event(chev), .o_rdata(o_rdata),
      .o_waveform_output_pins(pins), .o_irq(o_irq), .o_dma_req(dma),
      .o_ovf_event(ovf), .o_mc_event(mc));
   power_driver_model u_drv (.i_clk(i_clk), .i_clear(clr), .i_gate(pins),
      .o_high_cycles(hi));
   // Counts the compare match pulses of each channel since the last clear.
   always @(posedge i_clk)
      for (int c = 0; c < 4; c++)
         mcn[c] <= clr ? 0 : mcn[c] + int'(mc[c]);
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] high_exp(input logic [31:0] c, tp, k);
      return k * ((c > tp) ? tp + 1 : c);
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // The counter clock runs before the block is used.
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      errors++;
      tally_and_finish();
   end
   // ----------------------------------------------------------------
   // Stimulus and checks
   // ----------------------------------------------------------------
   initial begin
      {i_reset, i_wr, i_rd, i_dbg_access, i_dbg_halt, i_cnt_event} = 6'h20;
      {clr, slp, chev, i_addr, i_wdata} = 46'h0;
      repeat (10) @(posedge i_clk);
      i_reset <= 1'b0;
      rd(8'h00, v); chk("ctrl", v, 32'h0);
      rd(8'h10, v); chk("cyclen", v, 32'h00ffffff);
      rd(8'h7c, v); chk("unmapped", v, 32'h0);
      wr(8'h18, 32'h1); wr(8'h00, 32'h2);
      rd(8'h00, v); chk("ctrl_guarded", v, 32'h0);
      wr(8'h10, 32'h64);
      rd(8'h10, v); chk("cyclen_open", v, 32'h64);
      i_dbg_access <= 1'b1;
      wr(8'h00, 32'h2);
      rd(8'h00, v); chk("ctrl_debugger", v, 32'h2);
      wr(8'h00, 32'h0); wr(8'h18, 32'h0);
      i_dbg_access <= 1'b0;
      for (t = 0; t < 4; t++) begin
         n = rnd() % 16 + 8;
         wr(8'h10, n);
         for (int c = 0; c < 4; c++) begin
            cc[c] = 24'(c == 0 ? rnd() % n + 4 : rnd() % (n + 4));
            wr(8'h20 + 8'(4 * c), {8'h0, cc[c]});
         end
         top = t[1] ? {8'h0, cc[0]} : n;
         wr(8'h0c, 32'h0); wr(8'h00, {28'h0, t[1], 1'b0, t[0], 1'b1});
         repeat (60) @(posedge i_clk);
         clr <= 1'b1;
         @(posedge i_clk);
         clr <= 1'b0;
         repeat (4 * (top + 1)) @(posedge i_clk);
         #1;
         for (int c = 0; c < 4; c++) begin
            v = {16'h0, hi[16*c +: 16]};
            chk("high", v, high_exp(cc[c], top, 4));
            chk("match_events", mcn[c], cc[c] <= top ? 32'h4 : 32'h0);
         end
         wr(8'h00, 32'h0);
      end
      n = rnd() % 32 + 8;
      wr(8'h40, 32'h1); wr(8'h10, n); wr(8'h0c, 32'h0); wr(8'h08, 32'hff);
      rd(8'h08, v); chk("flag_cleared", v & 32'h1, 32'h0);
      wr(8'h00, 32'h1);
      repeat (n - 3) @(posedge i_clk);
      #1 chk("irq_early", {31'h0, o_irq}, 32'h0);
      repeat (6) @(posedge i_clk);
      #1 chk("irq_wrap", {31'h0, o_irq}, 32'h1);
      rd(8'h08, v); chk("ovf_flag", v & 32'h1, 32'h1);
      wr(8'h10, 32'h8000); wr(8'h0c, 32'h4000);
      i_dbg_halt <= 1'b1;
      wr(8'h00, 32'h3); rd(8'h0c, v);
      repeat (5) @(posedge i_clk);
      rd(8'h0c, w); chk("halted", w, v);
      wr(8'h00, 32'h13); rd(8'h0c, v); rd(8'h0c, w);
      chk("debug_run_down", v - w, 32'h2);
      i_dbg_halt <= 1'b0;
      wr(8'h00, 32'h0); wr(8'h10, 32'h20); wr(8'h14, 32'h30);
      rd(8'h10, v); chk("shadow_held", v, 32'h20);
      wr(8'h0c, 32'h1e); wr(8'h00, 32'h1);
      repeat (10) @(posedge i_clk);
      rd(8'h10, v); chk("shadow_moved", v, 32'h30);
      wr(8'h00, 32'h0); wr(8'h10, 32'hff); wr(8'h0c, 32'h0);
      slp <= 1'b1;
      wr(8'h00, 32'h5);
      repeat (3) begin
         repeat (rnd() % 4 + 3) @(posedge i_clk);
         i_cnt_event <= 1'b1;
         repeat (rnd() % 4 + 3) @(posedge i_clk);
         i_cnt_event <= 1'b0;
      end
      repeat (6) @(posedge i_clk);
      rd(8'h0c, v); chk("event_count", v, 32'h3);
      w = rnd() & 32'h00ffffff;
      wr(8'h00, 32'h0); wr(8'h0c, w); wr(8'h00, 32'h400);
      chev <= 4'h4;
      repeat (4) @(posedge i_clk);
      chev <= 4'h0;
      repeat (4) @(posedge i_clk);
      rd(8'h28, v); chk("capture", v, w);
      wr(8'h0c, 32'h0); wr(8'h24, 32'hffffff); wr(8'h00, 32'hd001);
      repeat (4) @(posedge i_clk);
      #1 chk("pin_free", {31'h0, pins[1]}, 32'h1);
      chev <= 4'h1;
      repeat (5) @(posedge i_clk);
      #1 chk("pin_fault", {28'h0, pins}, 32'h0);
      wr(8'h00, 32'h5001); rd(8'h0c, v); rd(8'h0c, w);
      chk("fault_halt", w, v);
      chev <= 4'h0;
      tally_and_finish();
   end
endmodule
bind ctl_timer_core ctl_timer_checker #(.W(W), .NCH(NCH)) u_chk (
   .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .i_dbg_access(i_dbg_access),
   .i_dbg_halt(i_dbg_halt), .o_rdata(o_rdata), .o_irq(o_irq),
   .o_dma_req(o_dma_req), .o_ovf_event(o_ovf_event));
`default_nettype wire
